/* logic/dtc_timer_pair.v */
`timescale 1ns/1ps
`include "dtc_defines.vh"
module dtc_timer_pair (
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  input wire ext_irq_a_pin,
  input wire ext_irq_b_pin,
  input wire cnt_a_count_pin,
  input wire cnt_b_count_pin,
  input wire cnt_a_vector_ack,
  input wire cnt_b_vector_ack,
  output wire cnt_a_overflow_flag,
  output wire cnt_b_overflow_flag
);

////////////////////////////////////////////////////////////////////////////
// helpers

function reg_hit;
  input [7:0] addr;
  input [7:0] off;
  begin
    reg_hit = (addr == off);
  end
endfunction

// gating and source choice, identical for both counters
function cnt_step;
  input run;
  input gate_sel;
  input irq_level;
  input src_sel;
  input tick;
  input fall;
  begin
    cnt_step = run & (~gate_sel | irq_level) & (src_sel ? fall : tick);
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// state

reg [7:0] mode_q;
reg [7:0] a_lo_q;
reg [7:0] a_hi_q;
reg [7:0] b_lo_q;
reg [7:0] b_hi_q;
reg a_run_q;
reg b_run_q;
reg a_flag_q;
reg b_flag_q;
reg tick_q;
reg [7:0] rdata_q;

reg [7:0] a_lo_d;
reg [7:0] a_hi_d;
reg [7:0] b_lo_d;
reg [7:0] b_hi_d;
reg a_flag_d;
reg b_flag_d;
reg [7:0] rd_mux;

////////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire irq_a_level;
wire irq_b_level;
wire pin_a_fall;
wire pin_b_fall;

// gate inputs reset low so a gated counter stays still until the pin rises
dtc_pin_sync #(.RST_VAL(1'b0)) u_irq_a (
  .core_clk(core_clk),
  .resetn(resetn),
  .clk_en(clk_en),
  .pin_raw(ext_irq_a_pin),
  .pin_level(irq_a_level),
  .pin_fall()
);

dtc_pin_sync #(.RST_VAL(1'b0)) u_irq_b (
  .core_clk(core_clk),
  .resetn(resetn),
  .clk_en(clk_en),
  .pin_raw(ext_irq_b_pin),
  .pin_level(irq_b_level),
  .pin_fall()
);

// count pins idle high, so reset high avoids a false edge
dtc_pin_sync #(.RST_VAL(1'b1)) u_cnt_a (
  .core_clk(core_clk),
  .resetn(resetn),
  .clk_en(clk_en),
  .pin_raw(cnt_a_count_pin),
  .pin_level(),
  .pin_fall(pin_a_fall)
);

dtc_pin_sync #(.RST_VAL(1'b1)) u_cnt_b (
  .core_clk(core_clk),
  .resetn(resetn),
  .clk_en(clk_en),
  .pin_raw(cnt_b_count_pin),
  .pin_level(),
  .pin_fall(pin_b_fall)
);

////////////////////////////////////////////////////////////////////////////
// decode

// unmapped addresses fall through: writes ignored, reads give zero
wire wr_ctrl = reg_wr & reg_hit(reg_addr, `DTC_CTRL_OFF);
wire wr_mode = reg_wr & reg_hit(reg_addr, `DTC_MODE_OFF);
wire wr_a_lo = reg_wr & reg_hit(reg_addr, `DTC_A_LO_OFF);
wire wr_a_hi = reg_wr & reg_hit(reg_addr, `DTC_A_HI_OFF);
wire wr_b_lo = reg_wr & reg_hit(reg_addr, `DTC_B_LO_OFF);
wire wr_b_hi = reg_wr & reg_hit(reg_addr, `DTC_B_HI_OFF);

wire [1:0] a_mode = mode_q[`DTC_A_MODE_LSB+1:`DTC_A_MODE_LSB];
wire [1:0] b_mode = mode_q[`DTC_B_MODE_LSB+1:`DTC_B_MODE_LSB];
wire a_split = (a_mode == `DTC_MODE_SPLIT);
wire b_halt = (b_mode == `DTC_MODE_SPLIT);

////////////////////////////////////////////////////////////////////////////
// count enables

// tick_q is high every second cycle
// clk_en low stalls the prescaler too, so timer steps stretch with it
wire tick = tick_q;

wire a_inc = cnt_step(a_run_q, mode_q[`DTC_A_GATE_BIT], irq_a_level,
                      mode_q[`DTC_A_SRC_BIT], tick, pin_a_fall);

wire b_step = cnt_step(b_run_q, mode_q[`DTC_B_GATE_BIT], irq_b_level,
                       mode_q[`DTC_B_SRC_BIT], tick, pin_b_fall);
wire b_inc = b_step & ~b_halt;

// split high byte: timer ticks only, run from counter b's run bit
wire a_hi_inc = a_split & b_run_q & tick;

////////////////////////////////////////////////////////////////////////////
// counting

wire [7:0] a_lo_nx;
wire [7:0] a_hi_nx;
wire [7:0] b_lo_nx;
wire [7:0] b_hi_nx;
wire a_ovf;
wire a_hi_ovf;
wire b_ovf;

dtc_count_unit u_unit_a (
  .mode(a_mode),
  .lo(a_lo_q),
  .hi(a_hi_q),
  .inc_lo(a_inc),
  .inc_hi(a_hi_inc),
  .lo_nx(a_lo_nx),
  .hi_nx(a_hi_nx),
  .ovf_lo(a_ovf),
  .ovf_hi(a_hi_ovf)
);

dtc_count_unit u_unit_b (
  .mode(b_mode),
  .lo(b_lo_q),
  .hi(b_hi_q),
  .inc_lo(b_inc),
  .inc_hi(1'b0),
  .lo_nx(b_lo_nx),
  .hi_nx(b_hi_nx),
  .ovf_lo(b_ovf),
  .ovf_hi()
);

// in a's split mode b keeps counting unless b's own mode is also split, but its flag belongs to a's high byte
wire b_flag_set = a_split ? a_hi_ovf : b_ovf;

// software writes win over a same-cycle count update
always @* begin
  a_lo_d = wr_a_lo ? reg_wdata : a_lo_nx;
  a_hi_d = wr_a_hi ? reg_wdata : a_hi_nx;
  b_lo_d = wr_b_lo ? reg_wdata : b_lo_nx;
  b_hi_d = wr_b_hi ? reg_wdata : b_hi_nx;
end

// set beats clear, so an overflow in the acknowledge cycle survives
// software may still set or clear a flag through the control register
always @* begin
  a_flag_d = a_flag_q;
  if (a_ovf) begin
    a_flag_d = 1'b1;
  end else if (cnt_a_vector_ack) begin
    a_flag_d = 1'b0;
  end else if (wr_ctrl) begin
    a_flag_d = reg_wdata[`DTC_A_FLAG_BIT];
  end
  b_flag_d = b_flag_q;
  if (b_flag_set) begin
    b_flag_d = 1'b1;
  end else if (cnt_b_vector_ack) begin
    b_flag_d = 1'b0;
  end else if (wr_ctrl) begin
    b_flag_d = reg_wdata[`DTC_B_FLAG_BIT];
  end
end

////////////////////////////////////////////////////////////////////////////
// registers

always @(posedge core_clk or negedge resetn) begin
  if (!resetn) begin
    mode_q <= `DTC_CFG_RST;
    a_lo_q <= `DTC_CNT_RST;
    a_hi_q <= `DTC_CNT_RST;
    b_lo_q <= `DTC_CNT_RST;
    b_hi_q <= `DTC_CNT_RST;
    a_run_q <= 1'b0;
    b_run_q <= 1'b0;
    a_flag_q <= 1'b0;
    b_flag_q <= 1'b0;
    tick_q <= 1'b0;
  end else if (clk_en) begin
    tick_q <= ~tick_q;
    if (wr_mode) begin
      mode_q <= reg_wdata;
    end
    if (wr_ctrl) begin
      a_run_q <= reg_wdata[`DTC_A_RUN_BIT];
      b_run_q <= reg_wdata[`DTC_B_RUN_BIT];
    end
    a_lo_q <= a_lo_d;
    a_hi_q <= a_hi_d;
    b_lo_q <= b_lo_d;
    b_hi_q <= b_hi_d;
    a_flag_q <= a_flag_d;
    b_flag_q <= b_flag_d;
  end
end

////////////////////////////////////////////////////////////////////////////
// read path

always @* begin
  rd_mux = `DTC_RD_IDLE;
  case (reg_addr)
    `DTC_CTRL_OFF: begin
      rd_mux[`DTC_A_RUN_BIT] = a_run_q;
      rd_mux[`DTC_A_FLAG_BIT] = a_flag_q;
      rd_mux[`DTC_B_RUN_BIT] = b_run_q;
      rd_mux[`DTC_B_FLAG_BIT] = b_flag_q;
    end
    `DTC_MODE_OFF: begin
      rd_mux = mode_q;
    end
    `DTC_A_LO_OFF: begin
      rd_mux = a_lo_q;
    end
    `DTC_B_LO_OFF: begin
      rd_mux = b_lo_q;
    end
    `DTC_A_HI_OFF: begin
      rd_mux = a_hi_q;
    end
    `DTC_B_HI_OFF: begin
      rd_mux = b_hi_q;
    end
    default: begin
      rd_mux = `DTC_RD_IDLE;
    end
  endcase
end

// data held for one enabled cycle per read strobe, and kept while clk_en is low; zero otherwise
always @(posedge core_clk or negedge resetn) begin
  if (!resetn) begin
    rdata_q <= `DTC_RD_IDLE;
  end else if (clk_en) begin
    rdata_q <= reg_rd ? rd_mux : `DTC_RD_IDLE;
  end
end

assign reg_rdata = rdata_q;
assign cnt_a_overflow_flag = a_flag_q;
assign cnt_b_overflow_flag = b_flag_q;

endmodule // dtc_timer_pair

/* logic/dtc_defines.vh */
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// register offsets
`define DTC_CTRL_OFF 8'h88
`define DTC_MODE_OFF 8'h89
`define DTC_A_LO_OFF 8'h8a
`define DTC_B_LO_OFF 8'h8b
`define DTC_A_HI_OFF 8'h8c
`define DTC_B_HI_OFF 8'h8d

// mode config fields
`define DTC_A_MODE_LSB 0
`define DTC_A_SRC_BIT 2
`define DTC_A_GATE_BIT 3
`define DTC_B_MODE_LSB 4
`define DTC_B_SRC_BIT 6
`define DTC_B_GATE_BIT 7

// run and flag control fields
`define DTC_A_RUN_BIT 4
`define DTC_A_FLAG_BIT 5
`define DTC_B_RUN_BIT 6
`define DTC_B_FLAG_BIT 7

// counting modes
`define DTC_MODE_13 2'h0
`define DTC_MODE_16 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// reset values
`define DTC_CFG_RST 8'h00
`define DTC_CNT_RST 8'h00
`define DTC_RD_IDLE 8'h00

// timer mode steps once per this many clock cycles
`define DTC_TICK_CYCLES 2

`endif

/* logic/dtc_pin_sync.v */
`timescale 1ns/1ps
module dtc_pin_sync #(
  parameter RST_VAL = 1'b1
) (
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire pin_raw,
  output wire pin_level,
  output wire pin_fall
);

reg s1_q;
reg s2_q;
reg s3_q;
reg level_q;
reg fall_q;

// a change is accepted only once stages two and three agree
always @(posedge core_clk or negedge resetn) begin
  if (!resetn) begin
    s1_q <= RST_VAL;
    s2_q <= RST_VAL;
    s3_q <= RST_VAL;
    level_q <= RST_VAL;
    fall_q <= 1'b0;
  end else if (clk_en) begin
    s1_q <= pin_raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
    fall_q <= (s2_q == s3_q) & level_q & ~s3_q;
  end
end

assign pin_level = level_q;
assign pin_fall = fall_q;

endmodule // dtc_pin_sync

/* logic/dtc_count_unit.v */
`timescale 1ns/1ps
`include "dtc_defines.vh"
module dtc_count_unit (
  input wire [1:0] mode,
  input wire [7:0] lo,
  input wire [7:0] hi,
  input wire inc_lo,
  input wire inc_hi,
  output reg [7:0] lo_nx,
  output reg [7:0] hi_nx,
  output reg ovf_lo,
  output reg ovf_hi
);

wire [12:0] sum13;
wire [15:0] sum16;
wire [7:0] lo_inc;
wire [7:0] hi_inc;

assign sum13 = {hi, lo[4:0]} + 13'h0001;
assign sum16 = {hi, lo} + 16'h0001;
assign lo_inc = lo + 8'h01;
assign hi_inc = hi + 8'h01;

always @* begin
  lo_nx = lo;
  hi_nx = hi;
  ovf_lo = 1'b0;
  ovf_hi = 1'b0;
  case (mode)
    `DTC_MODE_13: begin
      // upper three low-byte bits are left alone
      if (inc_lo) begin
        hi_nx = sum13[12:5];
        lo_nx = {lo[7:5], sum13[4:0]};
        ovf_lo = &{hi, lo[4:0]};
      end
    end
    `DTC_MODE_16: begin
      if (inc_lo) begin
        hi_nx = sum16[15:8];
        lo_nx = sum16[7:0];
        ovf_lo = &{hi, lo};
      end
    end
    `DTC_MODE_RELOAD: begin
      if (inc_lo) begin
        lo_nx = (&lo) ? hi : lo_inc;
        ovf_lo = &lo;
      end
    end
    `DTC_MODE_SPLIT: begin
      if (inc_lo) begin
        lo_nx = lo_inc;
        ovf_lo = &lo;
      end
      if (inc_hi) begin
        hi_nx = hi_inc;
        ovf_hi = &hi;
      end
    end
    default: begin
      lo_nx = lo;
    end
  endcase
end

endmodule // dtc_count_unit

/* verification/dtc_chk_assertions.sv */
`timescale 1ns/1ps
`include "dtc_defines.vh"
module dtc_chk (
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire cnt_a_vector_ack,
  input wire cnt_b_vector_ack,
  input wire cnt_a_overflow_flag,
  input wire cnt_b_overflow_flag
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  AST_RD_IDLE: assert property (
    $past(clk_en) && !$past(reg_rd) |-> reg_rdata == `DTC_RD_IDLE)
    else $error("read data outside read slot");
  AST_RD_UNMAP: assert property (
    reg_rd && (reg_addr < `DTC_CTRL_OFF || reg_addr > `DTC_B_HI_OFF)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  // both run bits off first, so no count can race the read back
  AST_RD_BACK: assert property (
    reg_wr && reg_addr == `DTC_CTRL_OFF && !reg_wdata[4] && !reg_wdata[6]
    ##1 !reg_wr ##1 reg_wr && reg_addr > `DTC_CTRL_OFF
    && reg_addr <= `DTC_B_HI_OFF ##1 !reg_wr ##1 reg_rd
    && reg_addr == $past(reg_addr, 2) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("byte read back differs");
  AST_STOP_CLR: assert property (
    reg_wr && reg_addr == `DTC_CTRL_OFF && reg_wdata == 8'h00 ##1 !reg_wr
    ##1 reg_wr && reg_addr == `DTC_CTRL_OFF && reg_wdata == 8'h00
    |=> !cnt_a_overflow_flag && !cnt_b_overflow_flag)
    else $error("flag set while stopped");
  AST_CTRL_LOW: assert property (
    reg_rd && reg_addr == `DTC_CTRL_OFF |=> reg_rdata[3:0] == 4'h0)
    else $error("control low bits not zero");
  AST_A_HOLD: assert property (
    cnt_a_overflow_flag && !cnt_a_vector_ack && !reg_wr
    |=> cnt_a_overflow_flag) else $error("flag a dropped");
  AST_B_FALL: assert property (
    $fell(cnt_b_overflow_flag) |-> $past(cnt_b_vector_ack) || $past(reg_wr))
    else $error("flag b dropped");
  AST_A_ACK: assert property (
    reg_wr && reg_addr == `DTC_CTRL_OFF && !reg_wdata[4] && !reg_wdata[6]
    ##1 !reg_wr ##1 cnt_a_vector_ack && !reg_wr
    |=> !cnt_a_overflow_flag) else $error("ack left flag a set");
endmodule // dtc_chk
bind dtc_timer_pair dtc_chk chk (.core_clk(core_clk), .resetn(resetn),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cnt_a_vector_ack(cnt_a_vector_ack), .cnt_b_vector_ack(cnt_b_vector_ack),
  .cnt_a_overflow_flag(cnt_a_overflow_flag),
  .cnt_b_overflow_flag(cnt_b_overflow_flag));

/* verification/dtc_pin_model.sv */
`timescale 1ns/1ps
module dtc_pin_model (
  input wire core_clk,
  input wire [1:0] go,
  input wire [1:0] gl,
  output wire [1:0] cnt_pin,
  output wire [1:0] irq_pin
);
  int c [2] = '{0, 0};
  always @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (go[i]) c[i] <= 7;
      else if (c[i] > 0) c[i] <= c[i] - 1;
    end
  end
  // low 3 cycles per edge; offset so pins stay async to the clock
  assign #7 cnt_pin = {c[1] < 5, c[0] < 5};
  assign #7 irq_pin = gl;
endmodule // dtc_pin_model

/* verification/dtc_timer_pair_tb.sv */
`timescale 1ns/1ps
`include "dtc_defines.vh"
module dtc_timer_pair_tb;
  logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, en = 1;
  logic [7:0] reg_addr = 0, reg_wdata = 0, v;
  logic [1:0] ack = 0, go = 0, gl = 0;
  wire [1:0] cp, ip;
  wire [7:0] reg_rdata;
  wire fa, fb;
  int n_fail = 0, checked = 0, cyc = 0, te, i, r;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (resetn) cyc <= cyc + 1;
  always @(posedge core_clk) if (cyc > 3000) begin
    n_fail++;
    finish_test();
  end
  dtc_timer_pair dut (.core_clk(core_clk), .resetn(resetn), .clk_en(en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_a_pin(ip[0]),
    .ext_irq_b_pin(ip[1]), .cnt_a_count_pin(cp[0]),
    .cnt_b_count_pin(cp[1]), .cnt_a_vector_ack(ack[0]),
    .cnt_b_vector_ack(ack[1]), .cnt_a_overflow_flag(fa),
    .cnt_b_overflow_flag(fb));
  dtc_pin_model pins (.core_clk(core_clk), .go(go), .gl(gl), .cnt_pin(cp),
    .irq_pin(ip));
  ////////////////////////////////////////
  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ck(input string s, input int e, input logic [7:0] g);
    checked++;
    if (g !== e[7:0]) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", s, e[7:0], g);
    end
  endtask
  // one strobe cycle then a gap; read data caught mid-cycle
  task automatic op(input logic w, input logic [7:0] a, input int d);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d[7:0];
    @(posedge core_clk);
    te = cyc + 1;
    reg_wr <= 0;
    reg_rd <= 0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input int e);
    op(0, a, 0);
    ck("rdata", e, v);
  endtask
  task automatic adv(input int m, k, inout int lo, hi, f);
    int w;
    w = m ? 256 : 32;
    repeat (k) begin
      if (m >= 2) begin
        lo++;
        if (lo == 256) begin
          lo = (m == 2) ? hi : 0;
          f = 1;
        end
      end else begin
        lo = lo - lo % w + (lo + 1) % w;
        if (lo % w == 0) hi++;
        if (hi == 256) begin
          hi = 0;
          f = 1;
        end
      end
    end
  endtask
  task automatic scen(input logic [7:0] cfg, input logic [1:0] g, input int n);
    int lo[2], hi[2], f[2], e, s, k, m, x;
    @(posedge core_clk);
    gl <= g;
    op(1, `DTC_CTRL_OFF, 0);
    op(1, `DTC_CTRL_OFF, 0);
    op(1, `DTC_MODE_OFF, cfg);
    for (int i = 0; i < 2; i++) begin
      lo[i] = 240 + $urandom % 16;
      hi[i] = 254 + $urandom % 2;
      f[i] = 0;
      op(1, i ? `DTC_B_LO_OFF : `DTC_A_LO_OFF, lo[i]);
      op(1, i ? `DTC_B_HI_OFF : `DTC_A_HI_OFF, hi[i]);
    end
    op(1, `DTC_CTRL_OFF, 8'h50);
    e = te;
    repeat (n) begin
      @(posedge core_clk);
      go <= {cfg[6], cfg[2]};
      @(posedge core_clk);
      go <= 0;
      repeat (6) @(posedge core_clk);
    end
    // steps land on even edges; stop write lands two edges on
    @(negedge core_clk);
    s = (cyc + 2) / 2 - e / 2 - 1;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 2; i++) begin
        m = cfg[4*i +: 2];
        k = cfg[4*i+2] ? n * (1 - p) : (p ? 1 : s);
        if ((cfg[4*i+3] && !g[i]) || (i && m == 3)) k = 0;
        adv(m, k, lo[i], hi[i], f[i]);
      end
      if (cfg[1:0] == 3) adv(3, p ? 1 : s, hi[0], x, f[1]);
      if (!p) begin
        ck("flag_a", f[0], {7'h0, fa});
        ck("flag_b", f[1], {7'h0, fb});
      end
    end
    // rewrite the predicted flags so the stop write cannot mask them
    op(1, `DTC_CTRL_OFF, {f[1][0], 1'b0, f[0][0], 5'h0});
    @(posedge core_clk);
    ack <= 2'b11;
    @(posedge core_clk);
    ack <= 0;
    @(negedge core_clk);
    ck("flags", 0, {6'h0, fb, fa});
    rc(`DTC_CTRL_OFF, 0);
    for (int i = 0; i < 2; i++) begin
      rc(i ? `DTC_B_LO_OFF : `DTC_A_LO_OFF, lo[i]);
      rc(i ? `DTC_B_HI_OFF : `DTC_A_HI_OFF, hi[i]);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    r = $urandom(39);
    repeat (10) @(posedge core_clk);
    resetn <= 1;
    for (i = 'h87; i <= 'h8e; i++) rc(i[7:0], 0);
    for (i = 'h89; i <= 'h8d; i++) begin
      r = $urandom % 256;
      op(1, `DTC_CTRL_OFF, 0);
      op(1, i[7:0], r);
      rc(i[7:0], r);
    end
    for (i = 0; i < 4; i++) scen(8'(i * 17), 0, 4 + $urandom % 8);
    scen(8'h99, 2'b01, 6);
    scen(8'h99, 2'b10, 6);
    scen(8'h55, 0, 5);
    // clk_en low: a write must not land, the byte keeps its old value
    op(1, `DTC_A_LO_OFF, 8'h5a);
    @(posedge core_clk);
    en <= 0;
    op(1, `DTC_A_LO_OFF, 8'ha5);
    @(posedge core_clk);
    en <= 1;
    rc(`DTC_A_LO_OFF, 8'h5a);
    finish_test();
  end
endmodule // dtc_timer_pair_tb
